// ---- src/lp_pkg.sv ----
package lp_pkg;
    // ---------------------------------------------------------------
    // Clock and timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 25000;
    localparam int ALLBANK_REFRESH_CYCLE_NS = 130;
    localparam int PERBANK_REFRESH_CYCLE_NS = 60;
    localparam int PERBANK_SPACING_NS = 60;
    localparam int ABORT_EXTRA_PS = 17500;
    localparam int ALLBANK_REFRESH_CYCLES = (ALLBANK_REFRESH_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int PERBANK_REFRESH_CYCLES = (PERBANK_REFRESH_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int PERBANK_SPACING_CYCLES = (PERBANK_SPACING_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int ABORT_EXIT_DELAY_CYCLES = (PERBANK_REFRESH_CYCLE_NS * 1000 + ABORT_EXTRA_PS
        + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Cycle counts not printed for this block; plain defaults
    localparam int EXIT_TO_CMD_DELAY_CYCLES = 8;
    localparam int SR_MIN_RESIDENCY_CYCLES = 16;
    localparam int SELECT_HOLD_PERIOD_CYCLES = 3;
    localparam int CLOCK_HOLD_PERIOD_CYCLES = 5;
    localparam int PRE_EXIT_CLOCK_STABLE_CYCLES = 5;
    localparam int MIN_ENABLE_PULSE_CYCLES = 4;
    localparam int PD_EXIT_LATENCY_CYCLES = 4;
    localparam int INTERNAL_REFRESH_PERIOD_CYCLES = 156;
    localparam int CNT_W = 9;
    // ---------------------------------------------------------------
    // Command encodings (6-bit command/address, first edge)
    // ---------------------------------------------------------------
    localparam int CA_W = 6;
    localparam logic [5:0] CMD_MASK = 6'h1f;
    localparam logic [5:0] CMD_SR_ENTRY = 6'h18;
    localparam logic [5:0] CMD_SR_EXIT = 6'h14;
    localparam logic [5:0] CMD_ALLBANK_REF = 6'h08;
    localparam logic [5:0] CMD_PERBANK_REF = 6'h28;
    localparam logic [5:0] CMD_MODE_REG_READ = 6'h0e;
    localparam logic [5:0] CMD_MODE_REG_WRITE_FIRST = 6'h06;
    localparam logic [5:0] CMD_MODE_REG_WRITE_SECOND = 6'h16;
    localparam logic [5:0] CMD_MULTI_PURPOSE = 6'h00;
    localparam logic [5:0] CMD_COLUMN_SECOND = 6'h12;
    localparam logic [5:0] CMD_OTHER = 6'h02;
    // Restricted mode-register addresses
    localparam logic [5:0] MR_REFRESH_RATE = 6'h04;
    localparam logic [5:0] MR_PARTIAL_ARRAY_BANK = 6'h10;
    localparam logic [5:0] MR_PARTIAL_ARRAY_SEG = 6'h11;
    localparam int ABORT_ENABLE_BIT = 3;

    typedef enum {
        DEV_IDLE,
        DEV_SELF_REFRESH,
        DEV_EXIT_WAIT
    } dev_state_t;

    typedef enum {
        CTL_IDLE,
        CTL_SR,
        CTL_SR_EXIT_WAIT,
        CTL_EXTRA_REF,
        CTL_PD,
        CTL_PD_EXIT_WAIT
    } ctl_state_t;
endpackage : lp_pkg

// ---- src/lp_link_if.sv ----
`timescale 1ns/1ps
interface lp_link_if;
    logic clk_enable;
    logic chip_select;
    logic [5:0] command_address_bus;
    logic clk_running;

    modport device (
        input clk_enable,
        input chip_select,
        input command_address_bus,
        input clk_running
    );
    modport controller (
        output clk_enable,
        output chip_select,
        output command_address_bus,
        output clk_running
    );
endinterface : lp_link_if

// ---- src/lp_device_end.sv ----
`timescale 1ns/1ps
module lp_device_end #(
    parameter int DENSITY_GB = 2
) (
    input wire logic clk_i,
    input wire logic rst_i,
    lp_link_if.device link,
    output logic in_self_refresh_o,
    output logic in_power_down_o,
    output logic refresh_busy_o,
    output logic illegal_cmd_o,
    output logic [15:0] refresh_counter_o
);
    import lp_pkg::*;

    localparam bit ABORT_SUPPORTED = (DENSITY_GB >= 6);

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    logic [1:0] cke_sync_reg;
    logic [1:0] cs_sync_reg;
    logic [5:0] ca_meta_reg;
    logic [5:0] ca_sync_reg;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            // Pin idles high; a low reset value would fake a power-down entry
            cke_sync_reg <= 2'h3;
            cs_sync_reg <= 2'h0;
            ca_meta_reg <= 6'h00;
            ca_sync_reg <= 6'h00;
        end else begin
            cke_sync_reg <= {cke_sync_reg[0], link.clk_enable};
            cs_sync_reg <= {cs_sync_reg[0], link.chip_select};
            ca_meta_reg <= link.command_address_bus;
            ca_sync_reg <= ca_meta_reg;
        end
    end

    wire cke = cke_sync_reg[1];

    // ---------------------------------------------------------------
    // Power-down and input receivers
    // ---------------------------------------------------------------
    logic [CNT_W-1:0] clk_hold_reg;
    logic receivers_on_reg;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            clk_hold_reg <= '0;
            receivers_on_reg <= 1'b1;
            in_power_down_o <= 1'b0;
        end else begin
            in_power_down_o <= ~cke;
            if (cke) begin
                clk_hold_reg <= '0;
                receivers_on_reg <= 1'b1;
            end else if (clk_hold_reg == CNT_W'(CLOCK_HOLD_PERIOD_CYCLES)) begin
                receivers_on_reg <= 1'b0;
            end else begin
                clk_hold_reg <= clk_hold_reg + 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // Command decode (two-edge commands, second edge has select low)
    // ---------------------------------------------------------------
    logic first_reg;
    logic [5:0] first_ca_reg;
    logic cmd_valid;
    logic [5:0] cmd_code;

    wire accept_inputs = cke & receivers_on_reg;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            first_reg <= 1'b0;
            first_ca_reg <= 6'h00;
        end else begin
            first_reg <= accept_inputs & cs_sync_reg[1];
            if (accept_inputs & cs_sync_reg[1]) begin
                first_ca_reg <= ca_sync_reg;
            end
        end
    end

    // Second edge: select low, bits any level
    assign cmd_valid = first_reg & accept_inputs & ~cs_sync_reg[1];
    assign cmd_code = first_ca_reg;

    wire is_sre = cmd_valid && ((cmd_code & CMD_MASK) == CMD_SR_ENTRY);
    wire is_srx = cmd_valid && ((cmd_code & CMD_MASK) == CMD_SR_EXIT);
    wire is_allbank_refresh_cmd = cmd_valid && (cmd_code == CMD_ALLBANK_REF);
    wire is_perbank_refresh_cmd = cmd_valid && (cmd_code == CMD_PERBANK_REF);
    wire is_mrw1 = cmd_valid && (cmd_code == CMD_MODE_REG_WRITE_FIRST);
    wire mr_restricted = (ca_sync_reg == MR_PARTIAL_ARRAY_BANK)
        || (ca_sync_reg == MR_PARTIAL_ARRAY_SEG) || (ca_sync_reg == MR_REFRESH_RATE);
    wire is_allowed_sr = cmd_valid && (cmd_code == CMD_MODE_REG_READ
        || cmd_code == CMD_COLUMN_SECOND || cmd_code == CMD_MULTI_PURPOSE
        || cmd_code == CMD_MODE_REG_WRITE_SECOND || (is_mrw1 && !mr_restricted)
        || (cmd_code & CMD_MASK) == CMD_SR_EXIT);

    // ---------------------------------------------------------------
    // Self refresh state
    // ---------------------------------------------------------------
    dev_state_t state_reg;
    logic abort_enable_reg;
    logic [CNT_W-1:0] busy_cnt_reg;
    logic [CNT_W-1:0] self_timer_reg;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            abort_enable_reg <= 1'b0;
        end else if (is_mrw1 && ca_sync_reg == MR_REFRESH_RATE && state_reg == DEV_IDLE) begin
            abort_enable_reg <= ABORT_SUPPORTED;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= DEV_IDLE;
            illegal_cmd_o <= 1'b0;
        end else begin
            illegal_cmd_o <= 1'b0;
            case (state_reg)
                DEV_IDLE: begin
                    if (is_sre) begin
                        state_reg <= DEV_SELF_REFRESH;
                    end
                end
                DEV_SELF_REFRESH: begin
                    if (cmd_valid && !is_allowed_sr) begin
                        illegal_cmd_o <= 1'b1;
                    end
                    if (is_srx) begin
                        state_reg <= DEV_IDLE;
                    end
                end
                default: begin
                    state_reg <= DEV_IDLE;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Refresh engine: external commands and self-timed refresh
    // ---------------------------------------------------------------
    // Mode-register and multi-purpose commands never stall on busy
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_cnt_reg <= '0;
            self_timer_reg <= '0;
            refresh_counter_o <= 16'h0000;
        end else begin
            if (is_srx && state_reg == DEV_SELF_REFRESH && abort_enable_reg
                && busy_cnt_reg != '0) begin
                busy_cnt_reg <= '0; // counter left as is
            end else if (is_allbank_refresh_cmd) begin
                busy_cnt_reg <= CNT_W'(ALLBANK_REFRESH_CYCLES);
                refresh_counter_o <= refresh_counter_o + 16'h0001;
            end else if (is_perbank_refresh_cmd) begin
                busy_cnt_reg <= CNT_W'(PERBANK_REFRESH_CYCLES);
                refresh_counter_o <= refresh_counter_o + 16'h0001;
            end else if (state_reg == DEV_SELF_REFRESH && busy_cnt_reg == '0
                && self_timer_reg == '0) begin
                busy_cnt_reg <= CNT_W'(ALLBANK_REFRESH_CYCLES);
                refresh_counter_o <= refresh_counter_o + 16'h0001;
            end else if (busy_cnt_reg != '0) begin
                busy_cnt_reg <= busy_cnt_reg - 1'b1; // runs on in power-down
            end
            if (state_reg == DEV_SELF_REFRESH) begin
                self_timer_reg <= (self_timer_reg == '0)
                    ? CNT_W'(INTERNAL_REFRESH_PERIOD_CYCLES) : self_timer_reg - 1'b1;
            end else begin
                self_timer_reg <= CNT_W'(INTERNAL_REFRESH_PERIOD_CYCLES);
            end
        end
    end

    // Per-channel state only; nothing is shared with other instances
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            in_self_refresh_o <= 1'b0;
            refresh_busy_o <= 1'b0;
        end else begin
            in_self_refresh_o <= (state_reg == DEV_SELF_REFRESH);
            refresh_busy_o <= (busy_cnt_reg != '0);
        end
    end
endmodule : lp_device_end

// ---- src/lp_controller_end.sv ----
`timescale 1ns/1ps
module lp_controller_end (
    input wire logic clk_i,
    input wire logic rst_i,
    lp_link_if.controller link,
    input wire logic sr_enter_req_i,
    input wire logic sr_exit_req_i,
    input wire logic pd_enter_req_i,
    input wire logic pd_exit_req_i,
    input wire logic banks_idle_i,
    input wire logic busy_op_i,
    input wire logic abort_enabled_i,
    output logic cmd_ready_o,
    output logic in_self_refresh_o,
    output logic in_power_down_o
);
    import lp_pkg::*;

    // ---------------------------------------------------------------
    // Link drive
    // ---------------------------------------------------------------
    ctl_state_t state_reg;
    logic sr_flag_reg;
    logic need_extra_ref_reg;
    logic [1:0] edge_reg;
    logic [5:0] cmd_reg;
    logic [CNT_W-1:0] wait_reg;
    logic [CNT_W-1:0] resid_reg;
    logic [CNT_W-1:0] pulse_reg;

    wire pulse_ok = (pulse_reg == '0);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= CTL_IDLE;
            sr_flag_reg <= 1'b0;
            need_extra_ref_reg <= 1'b0;
            edge_reg <= 2'h0;
            cmd_reg <= 6'h00;
            wait_reg <= '0;
            resid_reg <= '0;
            pulse_reg <= '0;
            link.clk_enable <= 1'b1;
            link.chip_select <= 1'b0;
            link.command_address_bus <= 6'h00;
            link.clk_running <= 1'b1;
            cmd_ready_o <= 1'b0;
        end else begin
            link.clk_running <= 1'b1;
            if (wait_reg != '0) wait_reg <= wait_reg - 1'b1;
            if (resid_reg != '0) resid_reg <= resid_reg - 1'b1;
            if (pulse_reg != '0) pulse_reg <= pulse_reg - 1'b1;
            // Two-edge command shifter: select high then low
            if (edge_reg == 2'h2) begin
                link.chip_select <= 1'b1;
                link.command_address_bus <= cmd_reg;
                edge_reg <= 2'h1;
            end else if (edge_reg == 2'h1) begin
                link.chip_select <= 1'b0;
                link.command_address_bus <= 6'h00;
                edge_reg <= 2'h0;
            end
            cmd_ready_o <= (state_reg == CTL_IDLE) && wait_reg == '0 && edge_reg == 2'h0;
            case (state_reg)
                CTL_IDLE: begin
                    if (edge_reg == 2'h0 && wait_reg == '0) begin
                        if (need_extra_ref_reg) begin
                            cmd_reg <= CMD_ALLBANK_REF;
                            edge_reg <= 2'h2;
                            wait_reg <= CNT_W'(ALLBANK_REFRESH_CYCLES);
                            need_extra_ref_reg <= 1'b0;
                        end else if (sr_enter_req_i && banks_idle_i) begin
                            cmd_reg <= CMD_SR_ENTRY;
                            edge_reg <= 2'h2;
                            resid_reg <= CNT_W'(SR_MIN_RESIDENCY_CYCLES);
                            sr_flag_reg <= 1'b1;
                            state_reg <= CTL_SR;
                        end else if (pd_enter_req_i && !busy_op_i && pulse_ok) begin
                            link.clk_enable <= 1'b0;
                            pulse_reg <= CNT_W'(MIN_ENABLE_PULSE_CYCLES);
                            wait_reg <= CNT_W'(CLOCK_HOLD_PERIOD_CYCLES);
                            state_reg <= CTL_PD;
                        end
                    end
                end
                CTL_SR: begin
                    if (edge_reg == 2'h0 && pd_enter_req_i && pulse_ok) begin
                        link.clk_enable <= 1'b0;
                        pulse_reg <= CNT_W'(MIN_ENABLE_PULSE_CYCLES);
                        wait_reg <= CNT_W'(CLOCK_HOLD_PERIOD_CYCLES);
                        state_reg <= CTL_PD;
                    end else if (edge_reg == 2'h0 && sr_exit_req_i && resid_reg == '0) begin
                        cmd_reg <= CMD_SR_EXIT;
                        edge_reg <= 2'h2;
                        wait_reg <= abort_enabled_i ? CNT_W'(ABORT_EXIT_DELAY_CYCLES)
                            : CNT_W'(EXIT_TO_CMD_DELAY_CYCLES);
                        state_reg <= CTL_SR_EXIT_WAIT;
                    end
                end
                CTL_SR_EXIT_WAIT: begin
                    sr_flag_reg <= 1'b0;
                    need_extra_ref_reg <= 1'b1;
                    if (wait_reg == '0) state_reg <= CTL_IDLE;
                end
                CTL_PD: begin
                    // Select held low by the shifter being idle
                    if (pd_exit_req_i && pulse_ok && wait_reg == '0) begin
                        link.clk_enable <= 1'b1;
                        pulse_reg <= CNT_W'(MIN_ENABLE_PULSE_CYCLES);
                        wait_reg <= CNT_W'(PD_EXIT_LATENCY_CYCLES);
                        state_reg <= CTL_PD_EXIT_WAIT;
                    end
                end
                CTL_PD_EXIT_WAIT: begin
                    if (wait_reg == '0) state_reg <= sr_flag_reg ? CTL_SR : CTL_IDLE;
                end
                default: state_reg <= CTL_IDLE;
            endcase
        end
    end

    // Clock never stops here, so pre-exit stability holds trivially
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            in_self_refresh_o <= 1'b0;
            in_power_down_o <= 1'b0;
        end else begin
            in_self_refresh_o <= sr_flag_reg;
            in_power_down_o <= (state_reg == CTL_PD);
        end
    end
endmodule : lp_controller_end

// ---- verification/lp_link_asserts.sv ----
`timescale 1ns/1ps
module lp_link_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clk_enable,
    input wire logic chip_select,
    input wire logic [5:0] command_address_bus,
    input wire logic clk_running,
    input wire logic abort_enabled_i
);
    import lp_pkg::*;
    logic sr_entry_cmd;
    logic sr_exit_cmd;
    logic allbank_refresh_cmd;
    logic [CNT_W-1:0] since_entry_reg;
    logic [CNT_W-1:0] since_exit_reg;
    logic owe_refresh_reg;
    int exit_delay;

    assign sr_entry_cmd = chip_select
        && ((command_address_bus & CMD_MASK) == (CMD_SR_ENTRY & CMD_MASK));
    assign sr_exit_cmd = chip_select && (command_address_bus == CMD_SR_EXIT);
    assign allbank_refresh_cmd = chip_select && (command_address_bus == CMD_ALLBANK_REF);
    assign exit_delay = abort_enabled_i ? ABORT_EXIT_DELAY_CYCLES : EXIT_TO_CMD_DELAY_CYCLES;

    // ---------------------------------------------------------------
    // Helper counters
    // ---------------------------------------------------------------
    // Both saturate so a long idle spell never wraps into a false short gap
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            since_entry_reg <= '0;
        end else if (sr_entry_cmd) begin
            since_entry_reg <= CNT_W'(1);
        end else if (since_entry_reg != '1) begin
            since_entry_reg <= since_entry_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            since_exit_reg <= '1;
        end else if (sr_exit_cmd) begin
            since_exit_reg <= CNT_W'(1);
        end else if (since_exit_reg != '1) begin
            since_exit_reg <= since_exit_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            owe_refresh_reg <= 1'b0;
        end else if (sr_exit_cmd) begin
            owe_refresh_reg <= 1'b1;
        end else if (allbank_refresh_cmd) begin
            owe_refresh_reg <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Properties
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    AST_CLOCK_RUNNING: assert property (clk_running)
        else $error("link clock reported stopped");
    AST_ENTRY_SECOND_EDGE: assert property (sr_entry_cmd |=> !chip_select)
        else $error("self refresh entry lacks its select-low second edge");
    AST_COMMAND_AWAKE: assert property (chip_select |-> clk_enable)
        else $error("command issued with clock enable low");
    AST_SELECT_HOLD: assert property ($fell(clk_enable) |-> !chip_select [*3])
        else $error("select not held low after clock enable fell");
    AST_ENABLE_LOW_PULSE: assert property ($fell(clk_enable) |-> !clk_enable [*4])
        else $error("clock enable low pulse too short");
    AST_ENABLE_HIGH_PULSE: assert property ($rose(clk_enable) |-> clk_enable [*4])
        else $error("clock enable high pulse too short");
    AST_PD_EXIT_LATENCY: assert property ($rose(clk_enable) |-> !chip_select [*4])
        else $error("command inside power-down exit latency");
    AST_SR_RESIDENCY: assert property (sr_exit_cmd
        |-> since_entry_reg >= SR_MIN_RESIDENCY_CYCLES)
        else $error("self refresh left before minimum residency");
    AST_EXIT_DELAY: assert property ((allbank_refresh_cmd || sr_entry_cmd)
        |-> since_exit_reg >= exit_delay)
        else $error("command too soon after self refresh exit");
    AST_EXTRA_REFRESH: assert property (sr_entry_cmd |-> !owe_refresh_reg)
        else $error("self refresh entered without extra refresh");

    cover property (sr_entry_cmd);
    cover property (sr_exit_cmd);
    cover property (allbank_refresh_cmd);
    cover property ($fell(clk_enable));
endmodule : lp_link_asserts

// ---- verification/tb_sdram_self_refresh_power_down.sv ----
`timescale 1ns/1ps
`define CHK(what, exp, got) \
    n_compared++; \
    if ((got) !== (exp)) begin \
        fails++; \
        $display("MISMATCH %s expected %0h seen %0h", what, exp, got); \
    end
`define WAIT_UNTIL(c, n) for (k = 0; k < (n) && !(c); k++) @(negedge clk_i);
module tb_sdram_self_refresh_power_down;
    import lp_pkg::*;
    logic clk_i, rst_i, sr_enter_req, sr_exit_req, pd_enter_req, pd_exit_req;
    logic banks_idle, busy_op, abort_enabled_i, ctl_ready, ctl_sr, ctl_pd;
    logic dev_sr, dev_pd, dev_busy, dev_illegal, d2_sr, d2_pd, d2_busy, d2_illegal;
    logic [15:0] dev_cnt, d2_cnt, c0;
    int fails, n_compared, n_illegal, n_illegal_a;
    lp_link_if link ();
    lp_link_if link2 ();

    lp_controller_end i_lp_controller_end (.clk_i(clk_i), .rst_i(rst_i), .link(link),
        .sr_enter_req_i(sr_enter_req), .sr_exit_req_i(sr_exit_req),
        .pd_enter_req_i(pd_enter_req), .pd_exit_req_i(pd_exit_req),
        .banks_idle_i(banks_idle), .busy_op_i(busy_op), .abort_enabled_i(abort_enabled_i),
        .cmd_ready_o(ctl_ready), .in_self_refresh_o(ctl_sr), .in_power_down_o(ctl_pd));
    lp_device_end i_lp_device_end (.clk_i(clk_i), .rst_i(rst_i), .link(link),
        .in_self_refresh_o(dev_sr), .in_power_down_o(dev_pd), .refresh_busy_o(dev_busy),
        .illegal_cmd_o(dev_illegal), .refresh_counter_o(dev_cnt));
    // Second device faces the bench, which breaks controller rules on purpose
    lp_device_end i_lp_device_end_b (.clk_i(clk_i), .rst_i(rst_i), .link(link2),
        .in_self_refresh_o(d2_sr), .in_power_down_o(d2_pd), .refresh_busy_o(d2_busy),
        .illegal_cmd_o(d2_illegal), .refresh_counter_o(d2_cnt));
    lp_link_asserts i_lp_link_asserts (.clk_i(clk_i), .rst_i(rst_i),
        .clk_enable(link.clk_enable), .chip_select(link.chip_select),
        .command_address_bus(link.command_address_bus), .clk_running(link.clk_running),
        .abort_enabled_i(abort_enabled_i));

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // Illegal flags are one-cycle pulses, so they are counted here
    always @(posedge clk_i) begin
        n_illegal <= n_illegal + int'(d2_illegal === 1'b1);
        n_illegal_a <= n_illegal_a + int'(dev_illegal !== 1'b0);
    end

    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic send2(input logic [5:0] code);
        link2.chip_select = 1'b1;
        link2.command_address_bus = code;
        @(negedge clk_i);
        link2.chip_select = 1'b0;
        link2.command_address_bus = ~code;
        repeat (2) @(negedge clk_i);
    endtask : send2

    task automatic enter_sr();
        int k;
        banks_idle = 1'b1;
        sr_enter_req = 1'b1;
        `WAIT_UNTIL(ctl_sr, 60)
        sr_enter_req = 1'b0;
        `WAIT_UNTIL(dev_sr, 20)
        `CHK("device in self refresh", 1'b1, dev_sr)
    endtask : enter_sr

    task automatic exit_sr();
        int k;
        int len;
        sr_exit_req = 1'b1;
        `WAIT_UNTIL(!ctl_sr, 80)
        sr_exit_req = 1'b0;
        `WAIT_UNTIL(!dev_sr, 30)
        `CHK("device left self refresh", 1'b0, dev_sr)
        `WAIT_UNTIL(dev_busy, 40)
        len = 0;
        while (dev_busy === 1'b1 && len < 200) begin
            len++;
            @(negedge clk_i);
        end
        `CHK("extra refresh busy cycles", ALLBANK_REFRESH_CYCLES, len)
    endtask : exit_sr

    task automatic pd_move(input logic enter);
        int k;
        pd_enter_req = enter;
        pd_exit_req = !enter;
        `WAIT_UNTIL(ctl_pd === enter, 60)
        pd_enter_req = 1'b0;
        pd_exit_req = 1'b0;
        `WAIT_UNTIL(dev_pd === enter, 30)
        `CHK("device power-down state", enter, dev_pd)
        `CHK("controller held off after power-down change", 1'b0, ctl_ready)
    endtask : pd_move

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_sr_basic();
        int k;
        enter_sr();
        c0 = dev_cnt;
        `WAIT_UNTIL(dev_cnt !== c0, 400)
        `CHK("self-timed refresh count moved", 1'b1, dev_cnt !== c0)
        exit_sr();
        $display("test sr_basic done");
    endtask : t_sr_basic

    task automatic t_sr_refused();
        banks_idle = 1'b0;
        sr_enter_req = 1'b1;
        repeat (40) @(negedge clk_i);
        `CHK("entry held off while banks busy", 1'b0, dev_sr)
        `CHK("controller ready while idle", 1'b1, ctl_ready)
        sr_enter_req = 1'b0;
        banks_idle = 1'b1;
        $display("test sr_refused done");
    endtask : t_sr_refused

    task automatic t_pd_plain();
        busy_op = 1'b1;
        pd_enter_req = 1'b1;
        repeat (30) @(negedge clk_i);
        `CHK("power-down held off during busy op", 1'b0, dev_pd)
        busy_op = 1'b0;
        pd_move(1'b1);
        c0 = dev_cnt;
        repeat (400) @(negedge clk_i);
        `CHK("no refresh in plain power-down", c0, dev_cnt)
        pd_move(1'b0);
        $display("test pd_plain done");
    endtask : t_pd_plain

    task automatic t_pd_in_sr();
        int k;
        enter_sr();
        pd_move(1'b1);
        `CHK("still in self refresh", 1'b1, dev_sr)
        c0 = dev_cnt;
        `WAIT_UNTIL(dev_cnt !== c0, 400)
        `CHK("refresh continues in power-down", 1'b1, dev_cnt !== c0)
        pd_move(1'b0);
        exit_sr();
        abort_enabled_i = 1'b1;
        enter_sr();
        exit_sr();
        abort_enabled_i = 1'b0;
        `CHK("controller caused no illegal command", 0, n_illegal_a)
        $display("test pd_in_sr done");
    endtask : t_pd_in_sr

    task automatic t_illegal();
        int k;
        int base;
        send2(CMD_SR_ENTRY);
        `WAIT_UNTIL(d2_sr, 20)
        base = n_illegal;
        send2(CMD_MULTI_PURPOSE);
        send2(CMD_MODE_REG_WRITE_FIRST);
        send2(CMD_MODE_REG_READ);
        repeat (6) @(negedge clk_i);
        `CHK("allowed commands not flagged", base, n_illegal)
        send2(CMD_ALLBANK_REF);
        repeat (6) @(negedge clk_i);
        `CHK("refresh flagged in self refresh", base + 1, n_illegal)
        link2.clk_enable = 1'b0;
        `WAIT_UNTIL(d2_pd, 20)
        `CHK("second device powered down", 1'b1, d2_pd)
        repeat (CLOCK_HOLD_PERIOD_CYCLES + 3) @(negedge clk_i);
        base = n_illegal;
        send2(CMD_ALLBANK_REF);
        repeat (6) @(negedge clk_i);
        `CHK("inputs ignored after clock hold", base, n_illegal)
        link2.clk_enable = 1'b1;
        `WAIT_UNTIL(!d2_pd, 20)
        repeat (PD_EXIT_LATENCY_CYCLES + 2) @(negedge clk_i);
        send2(CMD_SR_EXIT);
        `WAIT_UNTIL(!d2_sr, 30)
        repeat (EXIT_TO_CMD_DELAY_CYCLES + 2) @(negedge clk_i);
        send2(CMD_ALLBANK_REF);
        base = n_illegal;
        send2(CMD_MODE_REG_WRITE_FIRST);
        `CHK("commands overlap a refresh", 1'b1, d2_busy)
        send2(CMD_MULTI_PURPOSE);
        repeat (6) @(negedge clk_i);
        `CHK("mode and multi-purpose during refresh", base, n_illegal)
        $display("test illegal done");
    endtask : t_illegal

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        $display("watchdog expired");
        results();
    end

    initial begin
        {rst_i, banks_idle} = 2'b11;
        {sr_enter_req, sr_exit_req, pd_enter_req, pd_exit_req} = 4'h0;
        {busy_op, abort_enabled_i} = 2'b00;
        {link2.clk_enable, link2.chip_select, link2.clk_running} = 3'b101;
        link2.command_address_bus = 6'h00;
        fails = 0;
        n_compared = 0;
        repeat (3) @(negedge clk_i);
        rst_i = 1'b0;
        `CHK("clock enable after reset", 1'b1, link.clk_enable)
        `CHK("device idle after reset", 1'b0, dev_sr | dev_pd)
        t_sr_basic();
        t_sr_refused();
        t_pd_plain();
        t_pd_in_sr();
        t_illegal();
        results();
    end
endmodule : tb_sdram_self_refresh_power_down
